/* File: bench/crs_core_checker.sv */
// Port assertions of the register and stack core
`timescale 1ns/10ps
`default_nettype none
module crs_core_checker (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command port
	input wire logic cmd_valid,
	input wire crs_pkg::crs_op_e cmd_op,
	input wire logic [15:0] cmd_data,
	input wire logic ready,
	input wire logic done,
	// Interrupt and memory
	input wire logic irq_ack,
	input wire logic [15:0] mem_addr,
	input wire logic mem_wr,
	input wire logic mem_rd,
	// Programming model
	input wire logic [7:0] accumulator_first,
	input wire logic [7:0] accumulator_second,
	input wire logic [15:0] accumulator_pair,
	input wire logic [15:0] index_primary,
	input wire logic [15:0] index_secondary,
	input wire logic [15:0] stack_pointer,
	input wire logic [7:0] condition_code_register,
	input wire logic [15:0] eff_addr
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Command accepted at this edge
	logic take;
	assign take = cmd_valid && ready;
	pair_view_a: assert property (accumulator_pair == {accumulator_first, accumulator_second})
		else $error("pair view wrong");
	stack_push_a: assert property (mem_wr && stack_pointer != $past(stack_pointer) |->
		mem_addr == $past(stack_pointer) && stack_pointer == $past(stack_pointer) - 16'h0001) else $error("push order wrong");
	stack_pull_a: assert property (mem_rd && stack_pointer != $past(stack_pointer) |->
		stack_pointer == $past(stack_pointer) + 16'h0001 && mem_addr == stack_pointer) else $error("pull order wrong");
	ack_stack_a: assert property (irq_ack |-> ##1 mem_wr [*8] ##1 mem_wr)
		else $error("interrupt stacking short");
	mask_vec_a: assert property (irq_ack |-> ##9 condition_code_register[4])
		else $error("mask not set before vector");
	reset_fetch_a: assert property ($fell(rst) |-> ##[0:2] (mem_rd && mem_addr == 16'hFFFE)
		##1 (mem_rd && mem_addr == 16'hFFFF)) else $error("reset vector fetch wrong");
	ea_primary_a: assert property (take && cmd_op == crs_pkg::OP_EA_IDXP |=> done &&
		eff_addr == $past(index_primary) + ($past(cmd_data) & 16'h00FF)) else $error("primary address wrong");
	ea_second_a: assert property (take && cmd_op == crs_pkg::OP_EA_IDXS |=> !done ##1 done &&
		eff_addr == $past(index_secondary, 2) + ($past(cmd_data, 2) & 16'h00FF)) else $error("secondary address wrong");
	acc_add_a: assert property (take && cmd_op == crs_pkg::OP_ADD_ACC_PAIR |=>
		accumulator_first == $past(accumulator_first) + $past(accumulator_second)) else $error("pair add wrong");
	idx_add_a: assert property (take && cmd_op == crs_pkg::OP_ADD_B_IDXP |=>
		index_primary == $past(index_primary) + {8'h00, $past(accumulator_second)}) else $error("index add wrong");
	// Main scenarios
	cover property (irq_ack);
	cover property (take && cmd_op == crs_pkg::OP_RET_INT);
	cover property (take && cmd_op == crs_pkg::OP_CALL);
endmodule : crs_core_checker
bind crs_core crs_core_checker crs_core_checker_inst (.clk, .rst, .cmd_valid, .cmd_op, .cmd_data, .ready, .done,
	.irq_ack, .mem_addr, .mem_wr, .mem_rd, .accumulator_first, .accumulator_second, .accumulator_pair,
	.index_primary, .index_secondary, .stack_pointer, .condition_code_register, .eff_addr);
`default_nettype wire

/* File: bench/crs_core_tb.sv */
// Self-checking testbench of the register and stack core
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; $display("Error %0t: %h not %h", $time, a, b); end end
`define MEM crs_mem_model_inst.mem
module crs_core_tb;
	// Stimulus
	logic clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, irq_req = 1'b0, xirq_req = 1'b0;
	crs_pkg::crs_op_e cmd_op = crs_pkg::OP_NOP;
	logic [15:0] cmd_data = 16'h0000, irq_vec = 16'h0000;
	// Core outputs
	logic ready, done, irq_ack, mem_wr, mem_rd;
	logic [7:0] mem_wdata, mem_rdata, accumulator_first, accumulator_second, condition_code_register;
	logic [15:0] mem_addr, accumulator_pair, index_primary, index_secondary, stack_pointer, program_counter, eff_addr;
	int err_count = 0, tests_run = 0, lat;
	// 200 MHz clock
	always #2.5 clk = ~clk;
	crs_core crs_core_inst (.clk, .rst, .cmd_valid, .cmd_op, .cmd_data, .ready, .done, .irq_req, .irq_vec,
		.xirq_req, .xirq_vec(irq_vec), .irq_ack, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata,
		.accumulator_first, .accumulator_second, .accumulator_pair, .index_primary, .index_secondary,
		.stack_pointer, .program_counter, .condition_code_register, .eff_addr);
	crs_mem_model crs_mem_model_inst (.clk, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata);
	// Verdict and end of run
	task automatic finish_test();
		if (err_count == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : finish_test
	// A wait ran out
	task automatic hang();
		err_count++;
		$display("Error %0t: wait ran out", $time);
		finish_test();
	endtask : hang
	// Offer one command when ready, then count cycles to done
	task automatic issue(input crs_pkg::crs_op_e op, input logic [15:0] d);
		int i;
		for (i = 0; i < 200 && ready !== 1'b1; i++) begin @(posedge clk); #1; end
		if (i == 200) hang();
		cmd_valid = 1'b1; cmd_op = op; cmd_data = d;
		@(posedge clk); #1;
		cmd_valid = 1'b0;
		for (lat = 1; lat < 20 && done !== 1'b1; lat++) begin @(posedge clk); #1; end
		if (lat == 20) hang();
		// Idle edge: last bus write lands, strobe rests
		@(posedge clk); #1;
	endtask : issue
	// Reset, then the counter comes from the reset vector
	task automatic t_reset();
		`MEM[16'hFFFE] = 8'h12; `MEM[16'hFFFF] = 8'h34;
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		issue(crs_pkg::OP_NOP, 16'h0000);
		`CHK(program_counter, 16'h1234)
		`CHK(condition_code_register, 8'hD0)
	endtask : t_reset
	// Accumulators, pair and fixed-direction pair operations
	task automatic t_acc();
		issue(crs_pkg::OP_LD_PAIR, 16'h0901);
		`CHK(accumulator_first, 8'h09)
		`CHK(accumulator_pair, 16'h0901)
		issue(crs_pkg::OP_ADD_ACC_PAIR, 16'h0000);
		`CHK(accumulator_first, 8'h0A)
		issue(crs_pkg::OP_DEC_ADJ, 16'h0000);
		`CHK(accumulator_first, 8'h10)
		`CHK(accumulator_second, 8'h01)
		issue(crs_pkg::OP_LD_PAIR, 16'hA55A);
		issue(crs_pkg::OP_SUB_ACC_PAIR, 16'h0000);
		`CHK(accumulator_first, 8'h4B)
		issue(crs_pkg::OP_CMP_ACC_PAIR, 16'h0000);
		`CHK(accumulator_first, 8'h4B)
		`CHK(accumulator_second, 8'h5A)
		issue(crs_pkg::OP_ADD_PAIR16, 16'h60A6);
		`CHK(accumulator_pair, 16'hAC00)
		issue(crs_pkg::OP_WR_ACC1, 16'h5000);
		`CHK(`MEM[16'h5000], 8'hAC)
		issue(crs_pkg::OP_RD_ACC1, 16'hFFFE);
		`CHK(accumulator_first, 8'h12)
		`CHK(lat, 2)
	endtask : t_acc
	// Index adds, indexed addresses and the extra secondary cycle
	task automatic t_index();
		issue(crs_pkg::OP_LD_IDXP, 16'h1000);
		issue(crs_pkg::OP_LD_IDXS, 16'h2000);
		issue(crs_pkg::OP_LD_ACC2, 16'h00F0);
		issue(crs_pkg::OP_ADD_B_IDXP, 16'h0000);
		`CHK(lat, 1)
		`CHK(index_primary, 16'h10F0)
		issue(crs_pkg::OP_ADD_B_IDXS, 16'h0000);
		`CHK(lat, 2)
		`CHK(index_secondary, 16'h20F0)
		issue(crs_pkg::OP_EA_IDXP, 16'h00FF);
		`CHK(eff_addr, 16'h11EF)
		issue(crs_pkg::OP_EA_IDXS, 16'h0010);
		`CHK(lat, 2)
		`CHK(eff_addr, 16'h2100)
	endtask : t_index
	// Word and byte push and pull
	task automatic t_stack();
		issue(crs_pkg::OP_LOAD_STACK_INIT, 16'h0100);
		issue(crs_pkg::OP_PSH_IDXP, 16'h0000);
		`CHK(`MEM[16'h0100], 8'hF0)
		`CHK(`MEM[16'h00FF], 8'h10)
		`CHK(stack_pointer, 16'h00FE)
		issue(crs_pkg::OP_PUL_IDXS, 16'h0000);
		`CHK(index_secondary, 16'h10F0)
		`CHK(stack_pointer, 16'h0100)
		issue(crs_pkg::OP_PSH_ACC2, 16'h0000);
		issue(crs_pkg::OP_PUL_ACC1, 16'h0000);
		`CHK(accumulator_first, 8'hF0)
	endtask : t_stack
	// Call and return
	task automatic t_call();
		issue(crs_pkg::OP_LD_PCNT, 16'h4567);
		issue(crs_pkg::OP_CALL, 16'h8000);
		`CHK(`MEM[16'h0100], 8'h67)
		`CHK(`MEM[16'h00FF], 8'h45)
		`CHK(program_counter, 16'h8000)
		issue(crs_pkg::OP_RET, 16'h0000);
		`CHK(program_counter, 16'h4567)
		`CHK(stack_pointer, 16'h0100)
	endtask : t_call
	// Unmask, take an interrupt, return from it
	task automatic t_irq();
		int i;
		issue(crs_pkg::OP_LD_ACC1, 16'h0000);
		issue(crs_pkg::OP_FIRST_TO_FLAGS, 16'h0000);
		`CHK(condition_code_register, 8'h00)
		issue(crs_pkg::OP_LD_ACC1, 16'h0055);
		issue(crs_pkg::OP_FLAGS_TO_FIRST, 16'h0000);
		`CHK(accumulator_first, 8'h00)
		`MEM[16'h3000] = 8'h9A; `MEM[16'h3001] = 8'hBC;
		irq_vec = 16'h3000; irq_req = 1'b1;
		for (i = 0; i < 100 && irq_ack !== 1'b1; i++) begin @(posedge clk); #1; end
		if (i == 100) hang();
		irq_req = 1'b0;
		issue(crs_pkg::OP_NOP, 16'h0000);
		`CHK(program_counter, 16'h9ABC)
		`CHK(condition_code_register[4], 1'b1)
		`CHK(stack_pointer, 16'h00F7)
		`CHK(`MEM[16'h0100], 8'h67)
		`CHK(`MEM[16'h00F8], 8'h00)
		issue(crs_pkg::OP_RET_INT, 16'h0000);
		`CHK(lat, 11)
		`CHK(program_counter, 16'h4567)
		`CHK(stack_pointer, 16'h0100)
		`CHK(condition_code_register, 8'h00)
		xirq_req = 1'b1;
		for (i = 0; i < 100 && irq_ack !== 1'b1; i++) begin @(posedge clk); #1; end
		if (i == 100) hang();
		xirq_req = 1'b0;
		issue(crs_pkg::OP_NOP, 16'h0000);
		`CHK(condition_code_register, 8'h50)
	endtask : t_irq
	// Main sequence
	initial begin
		t_reset();
		t_acc();
		t_index();
		t_stack();
		t_call();
		t_irq();
		finish_test();
	end
endmodule : crs_core_tb
`default_nettype wire

/* File: bench/crs_mem_model.sv */
// Byte memory standing on the core's bus
`timescale 1ns/10ps
`default_nettype none
module crs_mem_model (
	// Clock
	input wire logic clk,
	// Bus from the core
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_wr,
	input wire logic mem_rd,
	// Read data
	output logic [7:0] mem_rdata
);
	// Flat 64-Kbyte store, every location a plain address
	logic [7:0] mem [0:65535];
	// Last value read, kept to spoil idle data
	logic [7:0] last_q;
	// One-cycle writes and reads, same for every address
	always @(posedge clk) begin
		if (mem_wr) begin
			mem[mem_addr] <= mem_wdata;
		end
		if (mem_rd) begin
			last_q <= mem[mem_addr];
		end
	end
	// Same-cycle read data; an idle bus shows the inverse of the last value
	assign mem_rdata = mem_rd ? mem[mem_addr] : ~last_q;
endmodule : crs_mem_model
`default_nettype wire

/* File: design/crs_alu.sv */
// Accumulator arithmetic: add, subtract and decimal adjust
`timescale 1ns/10ps
`default_nettype none
`include "crs_params.svh"
module crs_alu (
	// Selection
	input wire crs_pkg::crs_alu_e sel,
	// Operands
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic [7:0] flags_in,
	// Results
	output logic [7:0] res,
	output logic [7:0] flags_out
);
	logic [8:0] sum9; // Sum with carry out
	logic [8:0] dif9; // Difference with borrow
	logic [4:0] half; // Low nibble sum
	logic [7:0] corr; // Decimal correction
	// ****************************************
	// Arithmetic
	// ****************************************
	always_comb begin
		sum9 = {1'b0, a} + {1'b0, b};
		dif9 = {1'b0, a} - {1'b0, b};
		half = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		corr = 8'h00;
		flags_out = flags_in;
		res = a;
		case (sel)
			// First plus second, half carry kept
			crs_pkg::AL_ADD: begin
				res = sum9[7:0];
				flags_out[`CRS_FC] = sum9[8];
				flags_out[`CRS_FH] = half[4];
				flags_out[`CRS_FV] = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
			end
			// First minus second, fixed direction
			crs_pkg::AL_SUB: begin
				res = dif9[7:0];
				flags_out[`CRS_FC] = dif9[8];
				flags_out[`CRS_FV] = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
			end
			// Decimal correction of the first accumulator
			crs_pkg::AL_DEC: begin
				if (flags_in[`CRS_FH] || a[3:0] > 4'h9) begin
					corr[3:0] = 4'h6;
				end
				if (flags_in[`CRS_FC] || a[7:4] > 4'h9 || (a[7:4] > 4'h8 && a[3:0] > 4'h9)) begin
					corr[7:4] = 4'h6;
					flags_out[`CRS_FC] = 1'b1;
				end
				res = a + corr;
			end
			default: begin
				res = a;
			end
		endcase
		flags_out[`CRS_FN] = res[7];
		flags_out[`CRS_FZ] = (res == 8'h00);
	end
endmodule : crs_alu
`default_nettype wire

/* File: design/crs_core.sv */
// CPU programming model: accumulators, index registers, stack and program counter
// Functional notes
// [RULE_01] Two 8-bit general accumulators
// [RULE_02] Accumulators also act as 16-bit pair
// [RULE_03] First accumulator is pair upper byte
// [RULE_04] Second accumulator adds to either index
// [RULE_05] Flag transfers use first accumulator only
// [RULE_06] Decimal adjust acts on first only
// [RULE_07] Pair add/subtract/compare: one direction only
// [RULE_08] Index plus 8-bit offset gives address
// [RULE_09] Secondary index costs one extra cycle
// [RULE_10] Stack pointer: next free, grows down
// [RULE_11] Push writes at pointer, then decrements
// [RULE_12] Pull increments pointer, then reads
// [RULE_13] Calls push return address, low first
// [RULE_14] Return pulls address into program counter
// [RULE_15] Interrupt stacks counter and all registers
// [RULE_16] Interrupt return unstacks in reverse order
// [RULE_17] Individual push/pull for each register; code has them for accumulators and indexes only
// [RULE_18] One flat 64-Kbyte memory map
// [RULE_19] Every memory access takes one cycle
// [RULE_20] Registers never appear in memory map
// [RULE_21] 16-bit counter loaded from vector
// [RULE_22] Mask bit set before vector fetch
`timescale 1ns/10ps
`default_nettype none
`include "crs_params.svh"
module crs_core (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Command port
	input wire logic cmd_valid,
	input wire crs_pkg::crs_op_e cmd_op,
	input wire logic [15:0] cmd_data,
	output logic ready,
	output logic done,
	// Interrupt requests
	input wire logic irq_req,
	input wire logic [15:0] irq_vec,
	input wire logic xirq_req,
	input wire logic [15:0] xirq_vec,
	output logic irq_ack,
	// Memory bus
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_wr,
	output logic mem_rd,
	input wire logic [7:0] mem_rdata,
	// Programming model view
	output logic [7:0] accumulator_first,
	output logic [7:0] accumulator_second,
	output logic [15:0] accumulator_pair,
	output logic [15:0] index_primary,
	output logic [15:0] index_secondary,
	output logic [15:0] stack_pointer,
	output logic [15:0] program_counter,
	output logic [7:0] condition_code_register,
	output logic [15:0] eff_addr
);
	// ****************************************
	// Declarations
	// ****************************************
	logic [7:0] acc1_q; // First accumulator
	logic [7:0] acc2_q; // Second accumulator
	logic [15:0] idxp_q; // Primary index
	logic [15:0] idxs_q; // Secondary index
	logic [15:0] sptr_q; // Stack pointer
	logic [15:0] pcnt_q; // Program counter
	logic [7:0] flags_q; // Condition codes
	crs_pkg::crs_state_e st_q; // Sequencer state
	crs_pkg::crs_state_e st_d; // Next state
	crs_pkg::crs_kind_e kind_q; // Running stack sequence
	logic [3:0] idx_q; // Step inside sequence
	logic int_q; // Interrupt entry running
	logic nmi_q; // Entry is non-maskable
	logic cmdrun_q; // Command in progress
	logic [15:0] vec_q; // Vector address
	logic [15:0] tgt_q; // Call target
	logic [7:0] off_q; // Held index offset
	logic xadd_q; // Extra cycle is an index add
	crs_pkg::crs_slot_e pslot_q; // Slot of read in flight
	logic take; // Command accepted
	logic int_go; // Interrupt recognised
	logic [3:0] len; // Sequence length
	logic last; // Final step of sequence
	crs_pkg::crs_slot_e cur_slot; // Slot of this step
	logic [7:0] push_byte; // Byte being stacked
	crs_pkg::crs_alu_e alu_sel; // Arithmetic selection
	logic [7:0] alu_res; // Arithmetic result
	logic [7:0] alu_flags; // Arithmetic flags
	logic [16:0] pair_sum; // Pair addition
	// ****************************************
	// Stack sequence tables
	// ****************************************
	// Length of each stacking kind
	function automatic logic [3:0] seq_len(input crs_pkg::crs_kind_e k);
		case (k)
			crs_pkg::SK_ALL: seq_len = `CRS_LEN_ALL;
			crs_pkg::SK_ACC1, crs_pkg::SK_ACC2: seq_len = `CRS_LEN_BYTE;
			default: seq_len = `CRS_LEN_WORD;
		endcase
	endfunction : seq_len
	// Push order; pulls walk it backwards
	function automatic crs_pkg::crs_slot_e seq_slot(input crs_pkg::crs_kind_e k, input logic [3:0] i);
		case (k)
			crs_pkg::SK_ALL: seq_slot = crs_pkg::crs_slot_e'(i); // [RULE_15]
			crs_pkg::SK_ACC1: seq_slot = crs_pkg::SL_ACC1;
			crs_pkg::SK_ACC2: seq_slot = crs_pkg::SL_ACC2;
			crs_pkg::SK_IDXP: seq_slot = i[0] ? crs_pkg::SL_IDXP_HI : crs_pkg::SL_IDXP_LO;
			crs_pkg::SK_IDXS: seq_slot = i[0] ? crs_pkg::SL_IDXS_HI : crs_pkg::SL_IDXS_LO;
			default: seq_slot = i[0] ? crs_pkg::SL_PCNT_HI : crs_pkg::SL_PCNT_LO; // [RULE_13]
		endcase
	endfunction : seq_slot
	// Stacking kind of a command
	function automatic crs_pkg::crs_kind_e op_kind(input crs_pkg::crs_op_e op);
		case (op)
			crs_pkg::OP_PSH_ACC1, crs_pkg::OP_PUL_ACC1: op_kind = crs_pkg::SK_ACC1; // [RULE_17]
			crs_pkg::OP_PSH_ACC2, crs_pkg::OP_PUL_ACC2: op_kind = crs_pkg::SK_ACC2;
			crs_pkg::OP_PSH_IDXP, crs_pkg::OP_PUL_IDXP: op_kind = crs_pkg::SK_IDXP;
			crs_pkg::OP_PSH_IDXS, crs_pkg::OP_PUL_IDXS: op_kind = crs_pkg::SK_IDXS;
			crs_pkg::OP_RET_INT: op_kind = crs_pkg::SK_ALL;
			default: op_kind = crs_pkg::SK_CALL;
		endcase
	endfunction : op_kind
	// ****************************************
	// Step decode
	// ****************************************
	// Command and interrupt acceptance; a command in hand wins
	always_comb begin
		take = ready & cmd_valid;
		int_go = (st_q == crs_pkg::ST_IDLE) && !take &&
			((xirq_req && !flags_q[`CRS_FX]) || (irq_req && !flags_q[`CRS_FI])); // [RULE_15]
		len = seq_len(kind_q);
		last = (idx_q == len - 4'h1);
		if (st_q == crs_pkg::ST_PULL) begin
			cur_slot = seq_slot(kind_q, len - 4'h1 - idx_q); // [RULE_16]
		end else begin
			cur_slot = seq_slot(kind_q, idx_q);
		end
	end
	// Byte offered to the stack
	always_comb begin
		case (cur_slot)
			crs_pkg::SL_PCNT_LO: push_byte = pcnt_q[7:0];
			crs_pkg::SL_PCNT_HI: push_byte = pcnt_q[15:8];
			crs_pkg::SL_IDXS_LO: push_byte = idxs_q[7:0];
			crs_pkg::SL_IDXS_HI: push_byte = idxs_q[15:8];
			crs_pkg::SL_IDXP_LO: push_byte = idxp_q[7:0];
			crs_pkg::SL_IDXP_HI: push_byte = idxp_q[15:8];
			crs_pkg::SL_ACC1: push_byte = acc1_q;
			crs_pkg::SL_ACC2: push_byte = acc2_q;
			default: push_byte = flags_q;
		endcase
	end
	// Next state
	always_comb begin
		st_d = st_q;
		case (st_q)
			crs_pkg::ST_IDLE: begin
				if (take) begin
					case (cmd_op)
						crs_pkg::OP_PSH_ACC1, crs_pkg::OP_PSH_ACC2, crs_pkg::OP_PSH_IDXP,
						crs_pkg::OP_PSH_IDXS, crs_pkg::OP_CALL: st_d = crs_pkg::ST_PUSH;
						crs_pkg::OP_PUL_ACC1, crs_pkg::OP_PUL_ACC2, crs_pkg::OP_PUL_IDXP,
						crs_pkg::OP_PUL_IDXS, crs_pkg::OP_RET,
						crs_pkg::OP_RET_INT: st_d = crs_pkg::ST_PULL;
						crs_pkg::OP_EA_IDXS, crs_pkg::OP_ADD_B_IDXS: st_d = crs_pkg::ST_EXTRA; // [RULE_09]
						crs_pkg::OP_RD_ACC1: st_d = crs_pkg::ST_DRAIN;
						default: st_d = crs_pkg::ST_IDLE;
					endcase
				end else if (int_go) begin
					st_d = crs_pkg::ST_PUSH;
				end
			end
			// Interrupt entry goes on to the vector fetch
			crs_pkg::ST_PUSH: if (last) st_d = int_q ? crs_pkg::ST_VEC : crs_pkg::ST_IDLE;
			crs_pkg::ST_PULL: if (last) st_d = crs_pkg::ST_DRAIN;
			crs_pkg::ST_VEC: if (idx_q[0]) st_d = crs_pkg::ST_DRAIN;
			default: st_d = crs_pkg::ST_IDLE;
		endcase
	end
	// ****************************************
	// Arithmetic unit
	// ****************************************
	always_comb begin
		case (cmd_op)
			crs_pkg::OP_ADD_ACC_PAIR: alu_sel = crs_pkg::AL_ADD;
			crs_pkg::OP_DEC_ADJ: alu_sel = crs_pkg::AL_DEC;
			default: alu_sel = crs_pkg::AL_SUB;
		endcase
		pair_sum = {1'b0, acc1_q, acc2_q} + {1'b0, cmd_data};
	end
	crs_alu u_alu (
		.sel(alu_sel),
		.a(acc1_q),
		.b(acc2_q),
		.flags_in(flags_q),
		.res(alu_res),
		.flags_out(alu_flags)
	);
	// ****************************************
	// Sequencer
	// ****************************************
	// State, step counter and sequence context
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= crs_pkg::ST_VEC; // [RULE_21]
			idx_q <= 4'h0;
			kind_q <= crs_pkg::SK_CALL;
			int_q <= 1'b0;
			nmi_q <= 1'b0;
			cmdrun_q <= 1'b0;
			vec_q <= `CRS_RST_VEC;
			tgt_q <= `CRS_WORD_RST;
			off_q <= `CRS_BYTE_RST;
			xadd_q <= 1'b0;
		end else begin
			st_q <= st_d;
			// Count steps while a state repeats
			if (st_d == st_q && st_q != crs_pkg::ST_IDLE) begin
				idx_q <= idx_q + 4'h1;
			end else begin
				idx_q <= 4'h0;
			end
			cmdrun_q <= (st_d != crs_pkg::ST_IDLE) && (take || cmdrun_q);
			if (take) begin
				kind_q <= op_kind(cmd_op);
				tgt_q <= cmd_data;
				off_q <= cmd_data[7:0];
				xadd_q <= (cmd_op == crs_pkg::OP_ADD_B_IDXS);
			end else if (int_go) begin
				kind_q <= crs_pkg::SK_ALL;
				int_q <= 1'b1;
				nmi_q <= xirq_req && !flags_q[`CRS_FX];
				vec_q <= (xirq_req && !flags_q[`CRS_FX]) ? xirq_vec : irq_vec;
			end else if (st_q == crs_pkg::ST_PUSH && last) begin
				int_q <= 1'b0;
			end
		end
	end
	// Handshake outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			ready <= 1'b0;
			done <= 1'b0;
			irq_ack <= 1'b0;
		end else begin
			ready <= (st_d == crs_pkg::ST_IDLE);
			done <= (st_d == crs_pkg::ST_IDLE) && (take || cmdrun_q);
			irq_ack <= int_go;
		end
	end
	// ****************************************
	// Memory bus
	// ****************************************
	// One byte per cycle on a flat map; no decode of the register set
	always_ff @(posedge clk) begin
		if (rst) begin
			mem_addr <= `CRS_WORD_RST;
			mem_wdata <= `CRS_BYTE_RST;
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
			pslot_q <= crs_pkg::SL_PCNT_HI;
		end else begin
			mem_wr <= 1'b0;
			mem_rd <= 1'b0;
			if (take && cmd_op == crs_pkg::OP_WR_ACC1) begin
				mem_addr <= cmd_data; // [RULE_18] [RULE_19] [RULE_20]
				mem_wdata <= acc1_q;
				mem_wr <= 1'b1;
			end else if (take && cmd_op == crs_pkg::OP_RD_ACC1) begin
				mem_addr <= cmd_data; // [RULE_18] [RULE_19]
				mem_rd <= 1'b1;
				pslot_q <= crs_pkg::SL_ACC1;
			end else if (st_q == crs_pkg::ST_PUSH) begin
				mem_addr <= sptr_q; // [RULE_11]
				mem_wdata <= push_byte;
				mem_wr <= 1'b1;
			end else if (st_q == crs_pkg::ST_PULL) begin
				mem_addr <= sptr_q + 16'h0001; // [RULE_12]
				mem_rd <= 1'b1;
				pslot_q <= cur_slot;
			end else if (st_q == crs_pkg::ST_VEC) begin
				// High byte sits at the lower address
				mem_addr <= vec_q + {15'h0000, idx_q[0]}; // [RULE_21]
				mem_rd <= 1'b1;
				pslot_q <= idx_q[0] ? crs_pkg::SL_PCNT_LO : crs_pkg::SL_PCNT_HI;
			end
		end
	end
	// ****************************************
	// Programming model registers
	// ****************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			acc1_q <= `CRS_BYTE_RST;
			acc2_q <= `CRS_BYTE_RST;
			idxp_q <= `CRS_WORD_RST;
			idxs_q <= `CRS_WORD_RST;
			sptr_q <= `CRS_WORD_RST;
			pcnt_q <= `CRS_WORD_RST;
			flags_q <= `CRS_FLAGS_RST;
		end else begin
			// Read data lands in the slot that asked for it
			if (mem_rd) begin
				case (pslot_q)
					crs_pkg::SL_PCNT_LO: pcnt_q[7:0] <= mem_rdata; // [RULE_14]
					crs_pkg::SL_PCNT_HI: pcnt_q[15:8] <= mem_rdata;
					crs_pkg::SL_IDXS_LO: idxs_q[7:0] <= mem_rdata;
					crs_pkg::SL_IDXS_HI: idxs_q[15:8] <= mem_rdata;
					crs_pkg::SL_IDXP_LO: idxp_q[7:0] <= mem_rdata;
					crs_pkg::SL_IDXP_HI: idxp_q[15:8] <= mem_rdata;
					crs_pkg::SL_ACC1: acc1_q <= mem_rdata;
					crs_pkg::SL_ACC2: acc2_q <= mem_rdata;
					// Restored flags may clear but never set the X mask
					default: flags_q <= {mem_rdata[7], mem_rdata[6] & flags_q[`CRS_FX], mem_rdata[5:0]}; // [RULE_16]
				endcase
			end
			// Stack pointer walks down on push, up on pull
			if (st_q == crs_pkg::ST_PUSH) begin
				sptr_q <= sptr_q - 16'h0001; // [RULE_10] [RULE_11]
			end else if (st_q == crs_pkg::ST_PULL) begin
				sptr_q <= sptr_q + 16'h0001; // [RULE_12]
			end
			// End of stacking: call jumps, interrupt entry masks
			if (st_q == crs_pkg::ST_PUSH && last) begin
				if (int_q) begin
					flags_q[`CRS_FI] <= 1'b1; // [RULE_22]
					if (nmi_q) flags_q[`CRS_FX] <= 1'b1;
				end else if (kind_q == crs_pkg::SK_CALL) begin
					pcnt_q <= tgt_q; // [RULE_13]
				end
			end
			// Delayed secondary index add
			if (st_q == crs_pkg::ST_EXTRA && xadd_q) begin
				idxs_q <= idxs_q + {8'h00, acc2_q}; // [RULE_04] [RULE_09]
			end
			if (take) begin
				case (cmd_op)
					crs_pkg::OP_LD_ACC1: acc1_q <= cmd_data[7:0]; // [RULE_01]
					crs_pkg::OP_LD_ACC2: acc2_q <= cmd_data[7:0];
					crs_pkg::OP_LD_PAIR: {acc1_q, acc2_q} <= cmd_data; // [RULE_02] [RULE_03]
					crs_pkg::OP_ADD_PAIR16: begin
						{acc1_q, acc2_q} <= pair_sum[15:0]; // [RULE_02] [RULE_03]
						flags_q[`CRS_FC] <= pair_sum[16];
					end
					crs_pkg::OP_LD_IDXP: idxp_q <= cmd_data; // [RULE_08]
					crs_pkg::OP_LD_IDXS: idxs_q <= cmd_data;
					crs_pkg::OP_LOAD_STACK_INIT: sptr_q <= cmd_data; // [RULE_10]
					crs_pkg::OP_LD_PCNT: pcnt_q <= cmd_data; // [RULE_21]
					// Result into the first accumulator only
					crs_pkg::OP_ADD_ACC_PAIR, crs_pkg::OP_SUB_ACC_PAIR: begin
						acc1_q <= alu_res; // [RULE_07]
						flags_q <= alu_flags;
					end
					crs_pkg::OP_CMP_ACC_PAIR: flags_q <= alu_flags; // [RULE_07]
					crs_pkg::OP_DEC_ADJ: begin
						acc1_q <= alu_res; // [RULE_06]
						flags_q <= alu_flags;
					end
					crs_pkg::OP_ADD_B_IDXP: idxp_q <= idxp_q + {8'h00, acc2_q}; // [RULE_04]
					// Software may clear the X mask but not set it
					crs_pkg::OP_FIRST_TO_FLAGS: flags_q <= {acc1_q[7], acc1_q[6] & flags_q[`CRS_FX], acc1_q[5:0]}; // [RULE_05]
					crs_pkg::OP_FLAGS_TO_FIRST: acc1_q <= flags_q; // [RULE_05]
					default: acc1_q <= acc1_q;
				endcase
			end
		end
	end
	// ****************************************
	// Effective address
	// ****************************************
	// Secondary index result one cycle later
	always_ff @(posedge clk) begin
		if (rst) begin
			eff_addr <= `CRS_WORD_RST;
		end else if (take && cmd_op == crs_pkg::OP_EA_IDXP) begin
			eff_addr <= idxp_q + {8'h00, cmd_data[7:0]}; // [RULE_08]
		end else if (st_q == crs_pkg::ST_EXTRA && !xadd_q) begin
			eff_addr <= idxs_q + {8'h00, off_q}; // [RULE_08] [RULE_09]
		end
	end
	// ****************************************
	// Register view
	// ****************************************
	assign accumulator_first = acc1_q;
	assign accumulator_second = acc2_q;
	assign accumulator_pair = {acc1_q, acc2_q};
	assign index_primary = idxp_q;
	assign index_secondary = idxs_q;
	assign stack_pointer = sptr_q;
	assign program_counter = pcnt_q;
	assign condition_code_register = flags_q;
endmodule : crs_core
`default_nettype wire

/* File: design/crs_params.svh */
// Constants of the CPU register and stack core
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH
// ****************************************
// Reset values
// ****************************************
`define CRS_RST_VEC 16'hFFFE
`define CRS_FLAGS_RST 8'hD0
`define CRS_BYTE_RST 8'h00
`define CRS_WORD_RST 16'h0000
// ****************************************
// Flag bit positions
// ****************************************
`define CRS_FC 0
`define CRS_FV 1
`define CRS_FZ 2
`define CRS_FN 3
`define CRS_FI 4
`define CRS_FH 5
`define CRS_FX 6
`define CRS_FS 7
// ****************************************
// Stack sequence lengths
// ****************************************
`define CRS_LEN_ALL 4'h9
`define CRS_LEN_WORD 4'h2
`define CRS_LEN_BYTE 4'h1
`endif

/* File: design/crs_pkg.sv */
// Types of the CPU register and stack core
package crs_pkg;
	// Commands taken on the command port
	typedef enum logic [4:0] {
		OP_NOP, OP_LD_ACC1, OP_LD_ACC2, OP_LD_PAIR, OP_LD_IDXP, OP_LD_IDXS,
		OP_LOAD_STACK_INIT, OP_LD_PCNT, OP_ADD_PAIR16, OP_ADD_ACC_PAIR,
		OP_SUB_ACC_PAIR, OP_CMP_ACC_PAIR, OP_ADD_B_IDXP, OP_ADD_B_IDXS,
		OP_FIRST_TO_FLAGS, OP_FLAGS_TO_FIRST, OP_DEC_ADJ, OP_EA_IDXP,
		OP_EA_IDXS, OP_PSH_ACC1, OP_PSH_ACC2, OP_PSH_IDXP, OP_PSH_IDXS,
		OP_PUL_ACC1, OP_PUL_ACC2, OP_PUL_IDXP, OP_PUL_IDXS, OP_CALL,
		OP_RET, OP_RET_INT, OP_RD_ACC1, OP_WR_ACC1
	} crs_op_e;
	// Stack sequence kinds
	typedef enum logic [2:0] {SK_CALL, SK_ALL, SK_ACC1, SK_ACC2, SK_IDXP, SK_IDXS} crs_kind_e;
	// Byte slots of the programming model
	typedef enum logic [3:0] {
		SL_PCNT_LO, SL_PCNT_HI, SL_IDXS_LO, SL_IDXS_HI, SL_IDXP_LO,
		SL_IDXP_HI, SL_ACC1, SL_ACC2, SL_FLAGS
	} crs_slot_e;
	// Sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_PUSH, ST_PULL, ST_VEC, ST_EXTRA, ST_DRAIN} crs_state_e;
	// Accumulator arithmetic selections
	typedef enum logic [1:0] {AL_ADD, AL_SUB, AL_DEC} crs_alu_e;
endpackage : crs_pkg
